// ===== rtl/sshw_pkg.sv
// Constants, types and bit layout of the motion health status word.
// Assumes one 100 MHz system clock and an active-high asynchronous reset.
// Behaviour
// - Acknowledge rises on successful preset or error reset, drops when host clears command bit.
// - Encoder error flag set while encoder reports a fault.
// - Heartbeat bit toggles about every 500 ms.
// - Heartbeat toggles only in command mode, not configuration mode.
// - Torque-limit flag set while a torque limit is active during a move.
// - Invalid jog change sets flag, old values kept; valid write clears it.
// - Jog move takes live changes only to speed, accel, decel, max torque.
// - Safe-off discrepancy flag set on time limit exceeded; cleared only by power cycle.
// - Driver fault on overtemp, overcurrent or inactive safe input; self clearing.
// - Link-lost flag set when physical link returns; protocol losses ignored.
// - Safe-off engaged flag set and power removed when either safe input inactive.
// - Enable command during safe-off engaged answers with a command error.
// - Over-temperature flag set while processor temperature above 90 C.
// - Discrete inputs reported one when active per configured polarity.
// - Safe-off variant reports safe input b at bit 3, safe input a at bit 2.
// - Driver fault clears power-stage flag, disables driver, no motor current.
// - Drive re-enables only on a zero-to-one transition of enable bit.
// - Power-stage flag set while driver enabled and current available.
// - Stall flag set when position error exceeds configured limit.
package sshw_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned HEARTBEAT_MS    = 500;
  localparam int unsigned HEARTBEAT_CYC   = HEARTBEAT_MS * (CLK_HZ / 1000);
  localparam logic [7:0]  TEMP_LIMIT_C    = 8'h5a;
  localparam int unsigned JOG_W           = 16;

  // Bit positions of the status word
  localparam int unsigned B_POWER_ON   = 15;
  localparam int unsigned B_STALL      = 14;
  localparam int unsigned B_CMD_ACK    = 13;
  localparam int unsigned B_ENC_ERR    = 12;
  localparam int unsigned B_HEARTBEAT  = 11;
  localparam int unsigned B_TORQUE_LIM = 10;
  localparam int unsigned B_JOG_INV    = 9;
  localparam int unsigned B_SAFE_DISC  = 8;
  localparam int unsigned B_DRV_FAULT  = 7;
  localparam int unsigned B_LINK_LOST  = 6;
  localparam int unsigned B_SAFE_ENG   = 5;
  localparam int unsigned B_OVER_TEMP  = 4;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  typedef struct packed {
    logic [JOG_W-1:0] speed;
    logic [JOG_W-1:0] accel;
    logic [JOG_W-1:0] decel;
    logic [JOG_W-1:0] torque;
  } sshw_jog_t;
endpackage

// ===== rtl/sshw_jog_if.sv
// Jog parameter carrier between status top and the jog holder.
// Assumes single clock domain.
`timescale 1ns/10ps
interface sshw_jog_if;
  sshw_pkg::sshw_jog_t wr_params;
  logic                wr_strobe;
  logic                jog_active;
  sshw_pkg::sshw_jog_t live_params;
  logic                invalid;
  modport holder (input wr_params, wr_strobe, jog_active, output live_params, invalid);
  modport user   (output wr_params, wr_strobe, jog_active, input live_params, invalid);
endinterface

// ===== rtl/sshw_jog_hold.sv
// Holds live jog parameters; rejects invalid updates during a jog.
// Assumes a write strobe of one cycle; zero values count as invalid.
`timescale 1ns/10ps
module sshw_jog_hold (
  input  wire logic   clk_sys,
  input  wire logic   sys_rst,
  sshw_jog_if.holder  jog
);
  typedef struct packed {
    sshw_pkg::sshw_jog_t params;
    logic                invalid;
  } sshw_jog_state_t;

  sshw_jog_state_t st;
  sshw_jog_state_t next_st;
  logic            wr_ok;

  always_comb begin
    next_st = st;
    wr_ok   = (jog.wr_params.speed != '0) && (jog.wr_params.accel != '0) &&
              (jog.wr_params.decel != '0) && (jog.wr_params.torque != '0);
    if (jog.wr_strobe) begin
      if (wr_ok) begin
        next_st.params  = jog.wr_params;
        next_st.invalid = 1'b0;
      end else if (jog.jog_active) begin
        next_st.invalid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign jog.live_params = st.params;
  assign jog.invalid     = st.invalid;
endmodule // sshw_jog_hold

// ===== rtl/sshw_status_word.sv
// Builds the 16-bit motion health status word and drive enable control.
// Assumes all inputs synchronous to clk_sys; reset stands for power cycle.
`timescale 1ns/10ps
module sshw_status_word #(
  parameter int unsigned HEARTBEAT_CYC = sshw_pkg::HEARTBEAT_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        command_mode,
  input  wire logic        safe_variant,
  input  wire logic        preset_done_ok,
  input  wire logic        reset_errors_done_ok,
  input  wire logic        cmd_bit,
  input  wire logic        encoder_fault,
  input  wire logic        move_active,
  input  wire logic        torque_limit_hit,
  input  wire logic        jog_active,
  input  wire logic        jog_wr_strobe,
  input  wire sshw_pkg::sshw_jog_t jog_wr_params,
  input  wire logic        discrepancy_timeout,
  input  wire logic        overcurrent,
  input  wire logic        drive_overtemp,
  input  wire logic        safe_input_a_n,
  input  wire logic        safe_input_b_n,
  input  wire logic        phy_link_up,
  input  wire logic        link_lost_clear,
  input  wire logic [7:0]  cpu_temp_c,
  input  wire logic [3:0]  raw_inputs,
  input  wire logic [3:0]  input_active_high,
  input  wire logic        enable_driver_bit,
  input  wire logic        stall_over_limit,
  output logic [15:0]      motion_health_status,
  output logic             power_stage_enable,
  output logic             cmd_error_pulse,
  output sshw_pkg::sshw_jog_t jog_live_params
);
  typedef struct packed {
    logic [31:0] hb_count;
    logic        heartbeat;
    logic        cmd_ack;
    logic        safe_off_discrepancy_flag;
    logic        link_was_up;
    logic        link_lost;
    logic        power_on;
    logic        enable_prev;
    logic        cmd_error;
    logic [15:0] status;
  } sshw_state_t;

  sshw_state_t st;
  sshw_state_t next_st;
  sshw_jog_if  jog ();

  logic        safe_off_engaged_flag;
  logic        driver_fault;
  logic        over_temp;
  logic [3:0]  in_state;
  logic        input_one_state;
  logic        input_two_state;
  logic        input_three_state;
  logic        input_four_state;
  logic        enable_rise;
  logic [15:0] word;

  assign jog.wr_params  = jog_wr_params;
  assign jog.wr_strobe  = jog_wr_strobe;
  assign jog.jog_active = jog_active;

  sshw_jog_hold u_jog (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .jog     (jog)
  );

  // Per-input polarity
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_in
      assign in_state[gi] = raw_inputs[gi] ~^ input_active_high[gi];
    end
  endgenerate

  assign input_one_state   = in_state[0];
  assign input_two_state   = in_state[1];
  assign input_three_state = safe_variant ? ~safe_input_a_n : in_state[2];
  assign input_four_state  = safe_variant ? ~safe_input_b_n : in_state[3];

  assign safe_off_engaged_flag = safe_variant && (safe_input_a_n || safe_input_b_n);
  assign over_temp    = cpu_temp_c > sshw_pkg::TEMP_LIMIT_C;
  assign driver_fault = drive_overtemp || overcurrent || safe_off_engaged_flag;
  assign enable_rise  = enable_driver_bit && !st.enable_prev;

  always_comb begin
    next_st = st;
    next_st.enable_prev = enable_driver_bit;
    next_st.cmd_error   = 1'b0;

    // Heartbeat, frozen outside command mode
    if (command_mode) begin
      if (st.hb_count >= HEARTBEAT_CYC - 1) begin
        next_st.hb_count  = '0;
        next_st.heartbeat = ~st.heartbeat;
      end else begin
        next_st.hb_count = st.hb_count + 32'd1;
      end
    end else begin
      next_st.hb_count = '0;
    end

    // Ack holds until host drops command bit; completion wins
    if (!cmd_bit) begin
      next_st.cmd_ack = 1'b0;
    end
    if (preset_done_ok || reset_errors_done_ok) begin
      next_st.cmd_ack = 1'b1;
    end

    // Sticky until power cycle
    if (safe_variant && discrepancy_timeout) begin
      next_st.safe_off_discrepancy_flag = 1'b1;
    end

    // Physical link loss seen on return of link
    next_st.link_was_up = phy_link_up;
    if (link_lost_clear) begin
      next_st.link_lost = 1'b0;
    end
    if (phy_link_up && !st.link_was_up) begin
      next_st.link_lost = 1'b1;
    end

    // Drive enable control
    if (driver_fault) begin
      next_st.power_on = 1'b0;
    end else if (!enable_driver_bit) begin
      next_st.power_on = 1'b0;
    end else if (enable_rise) begin
      next_st.power_on = 1'b1;
    end
    if (enable_rise && safe_off_engaged_flag) begin
      next_st.cmd_error = 1'b1;
    end

    next_st.status = word;
  end

  always_comb begin
    word = sshw_pkg::STATUS_RESET;
    word[sshw_pkg::B_POWER_ON]   = st.power_on;
    word[sshw_pkg::B_STALL]      = stall_over_limit;
    word[sshw_pkg::B_CMD_ACK]    = st.cmd_ack;
    word[sshw_pkg::B_ENC_ERR]    = encoder_fault;
    word[sshw_pkg::B_HEARTBEAT]  = st.heartbeat;
    word[sshw_pkg::B_TORQUE_LIM] = move_active && torque_limit_hit;
    word[sshw_pkg::B_JOG_INV]    = jog.invalid;
    word[sshw_pkg::B_SAFE_DISC]  = st.safe_off_discrepancy_flag;
    word[sshw_pkg::B_DRV_FAULT]  = driver_fault;
    word[sshw_pkg::B_LINK_LOST]  = st.link_lost;
    word[sshw_pkg::B_SAFE_ENG]   = safe_off_engaged_flag;
    word[sshw_pkg::B_OVER_TEMP]  = over_temp;
    word[3:0] = {input_four_state, input_three_state, input_two_state, input_one_state};
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign motion_health_status = st.status;
  assign power_stage_enable   = st.power_on;
  assign cmd_error_pulse      = st.cmd_error;
  assign jog_live_params      = jog.live_params;
endmodule // sshw_status_word

// ===== dv/sshw_status_word_asserts.sv
// Checker for the motion health status word.
// Assumes the bind at the foot and one clock domain.
`timescale 1ns/10ps
module sshw_chk (
  input wire logic        clk_sys,
  input wire logic        sys_rst,
  input wire logic        command_mode,
  input wire logic        safe_variant,
  input wire logic        preset_done_ok,
  input wire logic        encoder_fault,
  input wire logic        overcurrent,
  input wire logic        drive_overtemp,
  input wire logic        safe_input_a_n,
  input wire logic        safe_input_b_n,
  input wire logic [7:0]  cpu_temp_c,
  input wire logic        enable_driver_bit,
  input wire logic [15:0] motion_health_status,
  input wire logic        power_stage_enable,
  input wire logic        cmd_error_pulse
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ack_rise_a: assert property (preset_done_ok |-> ##2 motion_health_status[13])
    else $error("ack not raised");
  enc_err_a: assert property (!$past(sys_rst) |-> motion_health_status[12] == $past(encoder_fault))
    else $error("encoder flag wrong");
  temp_flag_a: assert property (!$past(sys_rst) |-> motion_health_status[4] == ($past(cpu_temp_c) > 8'h5a))
    else $error("temperature flag wrong");
  fault_flag_a: assert property (!$past(sys_rst) |-> motion_health_status[7] ==
    $past(overcurrent | drive_overtemp | safe_variant & (safe_input_a_n | safe_input_b_n))) else $error("fault flag wrong");
  fault_off_a: assert property (overcurrent || drive_overtemp |=> !power_stage_enable)
    else $error("drive on during fault");
  enable_edge_a: assert property ($rose(power_stage_enable) |-> $past(enable_driver_bit) && !$past(enable_driver_bit, 2))
    else $error("enable without rising bit");
  power_flag_a: assert property (!$past(sys_rst) |-> motion_health_status[15] == $past(power_stage_enable))
    else $error("power flag wrong");
  hb_freeze_a: assert property (!$past(command_mode) && !$past(command_mode, 2) |-> $stable(motion_health_status[11]))
    else $error("heartbeat moved");
  disc_sticky_a: assert property (motion_health_status[8] |=> motion_health_status[8])
    else $error("discrepancy flag dropped");
  safe_err_a: assert property ($rose(enable_driver_bit) && motion_health_status[5] &&
    (safe_input_a_n || safe_input_b_n) |=> cmd_error_pulse) else $error("no command error");
endmodule // sshw_chk
bind sshw_status_word sshw_chk u_chk (.*);

// ===== dv/sshw_host.sv
// Host model: raises the command bit, drops it after the acknowledge.
// Assumes the status word of the block at its input.
`timescale 1ns/10ps
module sshw_host (
  input  wire logic        clk_sys,
  input  wire logic        cmd_req,
  input  wire logic [3:0]  lag,
  input  wire logic [15:0] motion_health_status,
  output logic             cmd_bit
);
  int wait_cnt = 0;
  initial cmd_bit = 1'b0;
  always @(posedge clk_sys) begin
    if (cmd_req) begin
      cmd_bit <= 1'b1;
    end else if (cmd_bit && motion_health_status[13]) begin
      wait_cnt <= wait_cnt + 1;
      if (wait_cnt >= lag) begin
        cmd_bit  <= 1'b0;
        wait_cnt <= 0;
      end
    end
  end
endmodule // sshw_host

// ===== dv/servo_status_word_one_tb.sv
// Testbench for the motion health status word with a host model.
// Assumes a 100 MHz clock and a heartbeat of 10 cycles.
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module servo_status_word_one_tb;
  logic clk_sys = 0, sys_rst = 1, command_mode = 0, safe_variant = 0, preset_done_ok = 0, reset_errors_done_ok = 0;
  logic encoder_fault = 0, move_active = 0, torque_limit_hit = 0, jog_active = 0, jog_wr_strobe = 0, rnd = 0;
  logic overcurrent = 0, drive_overtemp = 0, safe_input_a_n = 0, safe_input_b_n = 0, phy_link_up = 0, err_seen = 0;
  logic enable_driver_bit = 0, stall_over_limit = 0, discrepancy_timeout = 0, link_lost_clear = 0;
  logic cmd_req = 0, hb_last = 0;
  logic [15:0] exp_w;
  logic cmd_bit, power_stage_enable, cmd_error_pulse;
  logic [7:0] cpu_temp_c = 0;
  logic [3:0] raw_inputs = 0, input_active_high = 0, lag = 0;
  logic [15:0] motion_health_status;
  sshw_pkg::sshw_jog_t jog_wr_params = '0, jog_live_params;
  int bad_count = 0, total_checks = 0, hb_flips = 0, hb_mark, exp_q[$];
  sshw_status_word #(.HEARTBEAT_CYC(10)) dut (.*);
  sshw_host host (.*);
  initial forever #5 clk_sys = ~clk_sys;
  task automatic tick(int n = 1); repeat (n) @(posedge clk_sys); endtask
  task automatic test_done();
    if (bad_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function automatic int model();
    logic [3:0] act;
    act = ~(raw_inputs ^ input_active_high);
    if (safe_variant) act[3:2] = ~{safe_input_b_n, safe_input_a_n};
    return {stall_over_limit, 1'b0, encoder_fault, 1'b0, move_active & torque_limit_hit, 2'b00,
            overcurrent | drive_overtemp | safe_variant & (safe_input_a_n | safe_input_b_n), 2'b00, cpu_temp_c > 8'h5a, act};
  endfunction
  always @(posedge clk_sys) begin
    hb_flips += int'(motion_health_status[11] !== hb_last);
    hb_last = motion_health_status[11];
    if (cmd_error_pulse) err_seen <= 1'b1;
    if (rnd) begin
      if (exp_q.size() > 0) begin
        exp_w = 16'(exp_q.pop_front());
        `CHK("status", exp_w, motion_health_status & 16'h549f)
      end
      exp_q.push_back(model());
      {encoder_fault, stall_over_limit, move_active, torque_limit_hit, safe_input_a_n, safe_input_b_n, safe_variant} <= 7'($urandom);
      {raw_inputs, input_active_high} <= 8'($urandom);
      cpu_temp_c <= 8'(88 + $urandom % 5);
      overcurrent <= ($urandom % 8) == 0;
    end else exp_q.delete();
  end
  initial begin
    #50us;
    bad_count++;
    test_done();
  end
  initial begin
    void'($urandom(32'h9c416916));
    tick(20);
    sys_rst <= 0;
    tick(2);
    rnd <= 1;
    tick(300);
    rnd <= 0;
    tick();
    {overcurrent, safe_input_a_n, safe_input_b_n, safe_variant} <= '0;
    for (int i = 0; i < 2; i++) begin
      lag <= 4'(i * 5);
      cmd_req <= 1;
      tick();
      cmd_req <= 0;
      preset_done_ok <= i == 0;
      reset_errors_done_ok <= i == 1;
      tick();
      {preset_done_ok, reset_errors_done_ok} <= '0;
      tick(2);
      `CHK("ack", 1'b1, motion_health_status[13])
      tick(i * 5 + 4);
      `CHK("ack_clr", 1'b0, motion_health_status[13])
    end
    enable_driver_bit <= 1;
    tick(3);
    `CHK("pwr_on", 1'b1, power_stage_enable)
    overcurrent <= 1;
    tick();
    overcurrent <= 0;
    tick(3);
    `CHK("pwr_off", 1'b0, power_stage_enable)
    enable_driver_bit <= 0;
    tick();
    enable_driver_bit <= 1;
    tick(3);
    `CHK("pwr_again", 1'b1, power_stage_enable)
    {safe_variant, safe_input_a_n, enable_driver_bit} <= 3'b110;
    tick(3);
    `CHK("safe_eng", 2'b10, {motion_health_status[5], power_stage_enable})
    enable_driver_bit <= 1;
    discrepancy_timeout <= 1;
    tick();
    discrepancy_timeout <= 0;
    safe_input_a_n <= 0;
    tick(3);
    `CHK("safe_err", 1'b1, err_seen)
    `CHK("safe_flags", 2'b10, {motion_health_status[8], motion_health_status[5]})
    phy_link_up <= 1;
    tick(4);
    `CHK("link_set", 1'b1, motion_health_status[6])
    link_lost_clear <= 1;
    tick();
    link_lost_clear <= 0;
    tick(3);
    `CHK("link_clr", 1'b0, motion_health_status[6])
    jog_active <= 1;
    jog_wr_strobe <= 1;
    jog_wr_params <= {4{16'h0011}};
    tick();
    jog_wr_params <= {16'h0022, 16'h0000, 16'h0033, 16'h0044};
    tick();
    jog_wr_strobe <= 0;
    tick(3);
    `CHK("jog_bad", {1'b1, {4{16'h0011}}}, {motion_health_status[9], jog_live_params})
    jog_wr_strobe <= 1;
    jog_wr_params <= {4{16'h0055}};
    tick();
    jog_wr_strobe <= 0;
    tick(3);
    `CHK("jog_ok", {1'b0, {4{16'h0055}}}, {motion_health_status[9], jog_live_params})
    hb_mark = hb_flips;
    command_mode <= 1;
    tick(200);
    `CHK("hb_rate", 1'b1, (hb_flips - hb_mark) inside {[18:22]})
    command_mode <= 0;
    tick(3);
    hb_mark = hb_flips;
    tick(50);
    `CHK("hb_off", hb_mark, hb_flips)
    test_done();
  end
endmodule // servo_status_word_one_tb
